/* File: hdl/gsi_top.sv */
// Status lamps, two-digit display and configuration mode control.
// Functional notes
// - Error lamp dark when CAN is normal.
// - Error lamp steady on port error.
// - Error lamp blinks at error counter warning.
// - Run lamp on operational, 200/1000 ms stopped.
// - Run lamp 200/200 ms in pre-operational.
// - Transmit lamp blinks while sending.
// - Receive lamp blinks while receiving.
// - Serial lamps off on no link or error.
// - Display shows own address 01 to 99.
// - Display shows config code in config mode.
// - Double press enters configuration mode.
// - Double press in config restarts to operational.
// - Two exclusive roles chosen by configuration.
// - Master role enables SDO and PDO commands.
// - Modbus master role: codes 01-06,15,16; PDO only.
`timescale 1ns/1ps
`include "gsi_regs.svh"
module gsi_top #(
   parameter int MS_CYC = `GSI_MS_CYC // Clock cycles per millisecond.
) (
   input wire logic clk, // System clock, 40 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic btn_n, // Configuration button pin, low when pressed.
   input wire logic can_port_err, // CAN port error or bus-off, level.
   input wire logic can_err_warn, // Error counter at or above warning.
   input wire gsi_pkg::gsi_nmt_type nmt_state, // CANopen node state.
   input wire logic can_tx_fail, // Pulse: CAN frame transmission failed.
   input wire logic can_tx_ok, // Pulse: CAN frame sent successfully.
   input wire logic ser_tx_act, // Serial port sending data.
   input wire logic ser_rx_act, // Serial port receiving data.
   input wire logic ser_link_ok, // Serial port connected.
   input wire logic ser_err, // Serial port error.
   input wire logic [6:0] node_addr, // Own slave address.
   input wire gsi_pkg::gsi_role_type cfg_role, // Stored role.
   input wire logic [7:0] mb_func, // Modbus function code to check.
   output logic led_err, // Red CAN error lamp.
   output logic led_run, // Green CAN run lamp.
   output logic led_tx, // Green serial transmit lamp.
   output logic led_rx, // Green serial receive lamp.
   output logic [6:0] seg_hi, // Tens digit segments, gfedcba.
   output logic [6:0] seg_lo, // Units digit segments, gfedcba.
   output logic cfg_mode, // High while in configuration mode.
   output logic engine_rst, // Restart request to protocol engines.
   output gsi_pkg::gsi_role_type role, // Active role.
   output logic [3:0] can_cmd_en, // SDO up, SDO down, TPDO, RPDO enables.
   output logic mb_func_ok // Function code allowed in active role.
);
   import gsi_pkg::*;

   // Only a test bench should lower this, to keep runs short.
   localparam int MS = MS_CYC; // Cycles per millisecond.
   localparam int DEB_CYC = `GSI_DEBOUNCE_MS * MS; // Debounce time.
   localparam int WIN_CYC = `GSI_DBL_WIN_MS * MS; // Double press window.
   localparam int RST_CYC = `GSI_RESTART_MS * MS; // Restart delay.
   localparam int TEST_CYC = `GSI_LAMP_TEST_MS * MS; // Eights shown.
   localparam int ON_CYC = `GSI_RUN_ON_MS * MS; // Run lamp on time.
   localparam int STOP_CYC = `GSI_RUN_STOP_OFF_MS * MS; // Stop off time.
   localparam int PRE_CYC = `GSI_RUN_PRE_OFF_MS * MS; // Pre-op off time.
   localparam int BLK_CYC = `GSI_BLINK_MS * MS; // Blink half period.

   logic btn_s; // Synchronised button, high when pressed.
   logic btn_r; // Debounced button level.
   logic [19:0] deb_cnt_r; // Debounce counter.
   logic press; // One-cycle pulse on a debounced press.
   logic btn_d_r; // Previous debounced level.
   logic first_r; // First press seen, window open.
   logic [24:0] win_cnt_r; // Window counter.
   logic dbl; // Double press pulse.
   gsi_mode_type mode_r; // Operating mode.
   logic [24:0] rst_cnt_r; // Restart and lamp test counter.
   logic [25:0] run_cnt_r; // Run lamp phase counter.
   logic run_ph_r; // Run lamp phase, high means on.
   logic [22:0] blk_cnt_r; // Blink half period counter.
   logic blk_r; // Shared blink square wave.
   logic tx_fail_r; // Latched transmit failure.
   logic [3:0] tens; // Address tens digit.
   logic [3:0] units; // Address units digit.

   // Convert a decimal digit to segments.
   function automatic logic [6:0] seg_of(input logic [3:0] d);
      logic [6:0] s;
      s = `GSI_SEG_DASH;
      case (d)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         default: s = `GSI_SEG_DASH;
      endcase
      return s;
   endfunction

   // The button pin is asynchronous, so it is synchronised first.
   gsi_sync u_btn_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(~btn_n),
      .q(btn_s)
   );

   // Debounce: accept a new level only after it has held steady.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deb_cnt_r <= 20'h00000;
         btn_r <= 1'b0;
      end else if (btn_s == btn_r) begin
         deb_cnt_r <= 20'h00000;
      end else if (deb_cnt_r == 20'(DEB_CYC - 1)) begin
         deb_cnt_r <= 20'h00000;
         btn_r <= btn_s;
      end else begin
         deb_cnt_r <= deb_cnt_r + 20'h00001;
      end
   end

   // Edge of the debounced level marks one press.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         btn_d_r <= 1'b0;
      end else begin
         btn_d_r <= btn_r;
      end
   end
   assign press = btn_r & ~btn_d_r;

   // A second press inside the window makes a double press.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_r <= 1'b0;
         win_cnt_r <= 25'h0000000;
      end else if (press) begin
         first_r <= ~first_r;
         win_cnt_r <= 25'h0000000;
      end else if (first_r) begin
         if (win_cnt_r == 25'(WIN_CYC - 1)) begin
            first_r <= 1'b0; // Window expired, press forgotten.
         end else begin
            win_cnt_r <= win_cnt_r + 25'h0000001;
         end
      end
   end
   assign dbl = press & first_r;

   // Mode machine: normal, configuration and restart.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= GSI_MODE_RESTART;
         rst_cnt_r <= 25'h0000000;
      end else begin
         unique case (mode_r)
            GSI_MODE_NORMAL: begin
               if (dbl) begin
                  mode_r <= GSI_MODE_CONFIG;
               end
            end
            GSI_MODE_CONFIG: begin
               if (dbl) begin
                  mode_r <= GSI_MODE_RESTART;
                  rst_cnt_r <= 25'h0000000;
               end
            end
            GSI_MODE_RESTART: begin
               if (rst_cnt_r == 25'(RST_CYC - 1)) begin
                  mode_r <= GSI_MODE_NORMAL;
               end else begin
                  rst_cnt_r <= rst_cnt_r + 25'h0000001;
               end
            end
            default: mode_r <= GSI_MODE_RESTART;
         endcase
      end
   end

   // Run lamp phase generator, timing chosen by the node state.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_cnt_r <= 26'h0000000;
         run_ph_r <= 1'b1;
      end else if (run_ph_r && run_cnt_r >= 26'(ON_CYC - 1)) begin
         run_cnt_r <= 26'h0000000;
         run_ph_r <= 1'b0;
      end else if (!run_ph_r && nmt_state == GSI_NMT_STOP &&
                   run_cnt_r >= 26'(STOP_CYC - 1)) begin
         run_cnt_r <= 26'h0000000;
         run_ph_r <= 1'b1;
      end else if (!run_ph_r && nmt_state != GSI_NMT_STOP &&
                   run_cnt_r >= 26'(PRE_CYC - 1)) begin
         run_cnt_r <= 26'h0000000;
         run_ph_r <= 1'b1;
      end else begin
         run_cnt_r <= run_cnt_r + 26'h0000001;
      end
   end

   // Shared square wave for blinking lamps.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blk_cnt_r <= 23'h000000;
         blk_r <= 1'b0;
      end else if (blk_cnt_r == 23'(BLK_CYC - 1)) begin
         blk_cnt_r <= 23'h000000;
         blk_r <= ~blk_r;
      end else begin
         blk_cnt_r <= blk_cnt_r + 23'h000001;
      end
   end

   // CAN lamps: steady error overrides warning blink.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         led_err <= 1'b0;
         led_run <= 1'b0;
      end else begin
         if (can_port_err) begin
            led_err <= 1'b1;
         end else if (can_err_warn) begin
            led_err <= blk_r;
         end else begin
            led_err <= 1'b0;
         end
         unique case (nmt_state)
            GSI_NMT_OPER: led_run <= 1'b1;
            GSI_NMT_STOP: led_run <= run_ph_r;
            GSI_NMT_PREOP: led_run <= run_ph_r;
            GSI_NMT_INIT: led_run <= 1'b0;
         endcase
      end
   end

   // Serial lamps blink on activity, dark with no link or on error.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         led_tx <= 1'b0;
         led_rx <= 1'b0;
      end else if (!ser_link_ok || ser_err) begin
         led_tx <= 1'b0;
         led_rx <= 1'b0;
      end else begin
         led_tx <= ser_tx_act & blk_r;
         led_rx <= ser_rx_act & blk_r;
      end
   end

   // Transmit failure is held until a later frame succeeds.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_fail_r <= 1'b0;
      end else if (can_tx_fail) begin
         tx_fail_r <= 1'b1;
      end else if (can_tx_ok) begin
         tx_fail_r <= 1'b0;
      end
   end

   assign tens = 4'(node_addr / 7'd10);
   assign units = 4'(node_addr % 7'd10);

   // Display content by priority: restart, config, error, address.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seg_hi <= 7'h00;
         seg_lo <= 7'h00;
      end else if (mode_r == GSI_MODE_RESTART) begin
         if (rst_cnt_r < 25'(TEST_CYC)) begin
            seg_hi <= `GSI_SEG_8;
            seg_lo <= `GSI_SEG_8;
         end else begin
            seg_hi <= 7'h00;
            seg_lo <= 7'h00;
         end
      end else if (mode_r == GSI_MODE_CONFIG) begin
         seg_hi <= `GSI_SEG_C;
         seg_lo <= `GSI_SEG_F;
      end else if (tx_fail_r) begin
         seg_hi <= `GSI_SEG_E;
         seg_lo <= `GSI_SEG_O;
      end else if (node_addr >= `GSI_ADDR_MIN &&
                   node_addr <= `GSI_ADDR_MAX) begin
         seg_hi <= seg_of(tens);
         seg_lo <= seg_of(units);
      end else begin
         seg_hi <= `GSI_SEG_DASH;
         seg_lo <= `GSI_SEG_DASH;
      end
   end

   // Role, command enables and mode outputs.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         role <= GSI_ROLE_CAN_MASTER;
         can_cmd_en <= 4'h0;
         mb_func_ok <= 1'b0;
         cfg_mode <= 1'b0;
         engine_rst <= 1'b1;
      end else begin
         cfg_mode <= (mode_r == GSI_MODE_CONFIG);
         engine_rst <= (mode_r == GSI_MODE_RESTART);
         if (mode_r == GSI_MODE_RESTART) begin
            role <= cfg_role;
         end
         if (mode_r != GSI_MODE_NORMAL) begin
            can_cmd_en <= 4'h0;
            mb_func_ok <= 1'b0;
         end else if (role == GSI_ROLE_CAN_MASTER) begin
            can_cmd_en <= 4'hF;
            mb_func_ok <= 1'b0;
         end else begin
            can_cmd_en <= 4'h3;
            mb_func_ok <= (mb_func >= 8'h01 && mb_func <= 8'h06) ||
                          mb_func == 8'h0F || mb_func == 8'h10;
         end
      end
   end
endmodule

/* File: pkg/gsi_regs.svh */
// Timing counts and display codes for the gateway status indicator.
`ifndef GSI_REGS_SVH
`define GSI_REGS_SVH
`define GSI_CLK_HZ 40000000
`define GSI_RUN_ON_MS 200
`define GSI_RUN_STOP_OFF_MS 1000
`define GSI_RUN_PRE_OFF_MS 200
`define GSI_BLINK_MS 100
`define GSI_DEBOUNCE_MS 20
`define GSI_DBL_WIN_MS 400
`define GSI_RESTART_MS 500
`define GSI_LAMP_TEST_MS 300
`define GSI_MS_CYC (`GSI_CLK_HZ / 1000)
`define GSI_ADDR_MIN 7'h01
`define GSI_ADDR_MAX 7'h63
`define GSI_SEG_C 7'h39
`define GSI_SEG_F 7'h71
`define GSI_SEG_E 7'h79
`define GSI_SEG_O 7'h5C
`define GSI_SEG_8 7'h7F
`define GSI_SEG_DASH 7'h40
`endif

/* File: pkg/gsi_pkg.sv */
// Types shared by the gateway status indicator.
package gsi_pkg;
   // Network state reported by the CANopen engine.
   typedef enum logic [1:0] {
      GSI_NMT_INIT,
      GSI_NMT_PREOP,
      GSI_NMT_OPER,
      GSI_NMT_STOP
   } gsi_nmt_type;
   // Gateway role chosen by configuration.
   typedef enum logic {
      GSI_ROLE_CAN_MASTER,
      GSI_ROLE_MB_MASTER
   } gsi_role_type;
   // Operating mode of the gateway.
   typedef enum logic [1:0] {
      GSI_MODE_NORMAL,
      GSI_MODE_CONFIG,
      GSI_MODE_RESTART
   } gsi_mode_type;
endpackage

/* File: hdl/gsi_sync.sv */
// Two-flop synchroniser for a single level from outside the clock domain.
`timescale 1ns/1ps
module gsi_sync (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic d, // Asynchronous level.
   output logic q // Synchronised level.
);
   logic meta_r; // First stage, read only by the second stage.

   // Two stages remove metastability before any logic reads the level.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

/* File: bench/gsi_field.sv */
// Field-side model: an operator double-pressing the configuration button.
`timescale 1ns/1ps
module gsi_field #(
   parameter int MS = 40000 // Clock cycles per millisecond.
) (
   input wire logic clk, // System clock.
   input wire logic dbl_go, // Request one double press.
   output logic btn_n // Button pin, low while pressed.
);
   initial btn_n = 1'h1;
   // Two 60 ms presses 100 ms apart, long enough to pass the debounce.
   always @(posedge clk) begin
      if (dbl_go) begin
         repeat (2) begin
            btn_n <= 1'h0;
            repeat (60 * MS) @(posedge clk);
            btn_n <= 1'h1;
            repeat (100 * MS) @(posedge clk);
         end
      end
   end
endmodule

/* File: bench/gsi_top_asserts.sv */
// Concurrent checks on the status indicator ports.
`timescale 1ns/1ps
`include "gsi_regs.svh"
module gsi_top_asserts #(
   parameter int MS_CYC = `GSI_MS_CYC // Clock cycles per millisecond.
) (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic can_port_err, // CAN port error.
   input wire logic can_err_warn, // Error counter warning.
   input wire gsi_pkg::gsi_nmt_type nmt_state, // Node state.
   input wire logic ser_link_ok, // Serial link up.
   input wire logic ser_err, // Serial error.
   input wire logic [7:0] mb_func, // Function code asked about.
   input wire logic led_err, // Error lamp.
   input wire logic led_run, // Run lamp.
   input wire logic led_tx, // Transmit lamp.
   input wire logic led_rx, // Receive lamp.
   input wire logic [6:0] seg_hi, // Tens digit.
   input wire logic [6:0] seg_lo, // Units digit.
   input wire logic cfg_mode, // Configuration mode.
   input wire logic engine_rst, // Restart in progress.
   input wire gsi_pkg::gsi_role_type role, // Active role.
   input wire logic [3:0] can_cmd_en, // Command enables.
   input wire logic mb_func_ok // Function code allowed.
);
   import gsi_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   localparam int TEST_CYC = `GSI_LAMP_TEST_MS * MS_CYC; // Lamp test.
   localparam int RST_LO = `GSI_RESTART_MS * MS_CYC - 10; // Shortest.
   localparam int RST_HI = `GSI_RESTART_MS * MS_CYC + 10; // Longest.
   logic [24:0] rcnt_r; // Cycles spent in restart so far.
   logic norm_r; // Normal mode one cycle ago.
   // Time the restart and remember whether the last cycle was normal.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rcnt_r <= 25'h0000000;
         norm_r <= 1'h0;
      end else begin
         rcnt_r <= engine_rst ? rcnt_r + 25'h0000001 : 25'h0000000;
         norm_r <= !engine_rst && !cfg_mode;
      end
   end
   wire norm = norm_r && !engine_rst && !cfg_mode; // Settled normal mode.
   // Function codes that the serial master role may issue.
   function automatic logic fn_ok(logic [7:0] f);
      return (f >= 8'h01 && f <= 8'h06) || f == 8'h0F || f == 8'h10;
   endfunction
   // Configuration mode held for two cycles running.
   sequence s_cfg_held;
      cfg_mode [*2];
   endsequence
   AST_ERR_DARK: assert property (norm && !can_port_err && !can_err_warn
      |=> !led_err) else $error("error lamp lit on a healthy bus");
   AST_ERR_STEADY: assert property (norm && can_port_err
      |=> led_err) else $error("error lamp dark on port error");
   AST_RUN_OPER: assert property (norm && nmt_state == GSI_NMT_OPER
      |=> led_run) else $error("run lamp dark while operational");
   AST_SER_OFF: assert property (norm && (!ser_link_ok || ser_err)
      |=> !led_tx && !led_rx) else $error("serial lamp lit without link");
   AST_CFG_SHOW: assert property (s_cfg_held
      |-> seg_hi == 7'h39 && seg_lo == 7'h71) else $error("no config code");
   AST_CAN_ROLE: assert property (norm && role == GSI_ROLE_CAN_MASTER
      |-> can_cmd_en == 4'hF && !mb_func_ok) else $error("bad master set");
   AST_MB_ROLE: assert property (norm && role == GSI_ROLE_MB_MASTER
      |-> can_cmd_en == 4'h3 && mb_func_ok == fn_ok($past(mb_func)))
      else $error("bad serial master command set");
   AST_LAMP_TEST: assert property (engine_rst && rcnt_r >= 2
      && rcnt_r < TEST_CYC - 2 |-> seg_hi == 7'h7F && seg_lo == 7'h7F)
      else $error("segments not all lit in lamp test");
   AST_BLANK: assert property (engine_rst && rcnt_r > TEST_CYC + 2
      && rcnt_r < RST_LO |-> seg_hi == 7'h00 && seg_lo == 7'h00)
      else $error("display not blank after lamp test");
   AST_RESTART_LEN: assert property ($fell(engine_rst)
      |-> $past(rcnt_r) >= RST_LO && $past(rcnt_r) <= RST_HI)
      else $error("restart length wrong");
endmodule
bind gsi_top gsi_top_asserts #(.MS_CYC(MS_CYC)) i_chk (.clk(clk),
   .rst_n(rst_n),
   .can_port_err(can_port_err), .can_err_warn(can_err_warn),
   .nmt_state(nmt_state), .ser_link_ok(ser_link_ok), .ser_err(ser_err),
   .mb_func(mb_func), .led_err(led_err), .led_run(led_run), .led_tx(led_tx),
   .led_rx(led_rx), .seg_hi(seg_hi), .seg_lo(seg_lo), .cfg_mode(cfg_mode),
   .engine_rst(engine_rst), .role(role), .can_cmd_en(can_cmd_en),
   .mb_func_ok(mb_func_ok));

/* File: bench/gsi_top_tb.sv */
// Self-checking bench for the gateway status indicator.
`timescale 1ns/1ps
module gsi_top_tb;
   import gsi_pkg::*;
   // Time is scaled down so that the whole run stays short.
   localparam int MS = 10; // Clock cycles per millisecond.
   // One lamp case: inputs, window and expected lit time of each lamp.
   typedef struct {
      logic pe;
      logic wn;
      gsi_nmt_type st;
      logic [3:0] sr; // Serial sending, receiving, link, error.
      int win;
      int e[4]; // Lit ms of err, run, tx, rx; -1 is not judged.
   } gsi_row_type;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic btn_n, can_port_err = 1'h0, can_err_warn = 1'h0;
   gsi_nmt_type nmt_state = GSI_NMT_OPER;
   logic can_tx_fail = 1'h0, can_tx_ok = 1'h0, ser_tx_act = 1'h0;
   logic ser_rx_act = 1'h0, ser_link_ok = 1'h1, ser_err = 1'h0;
   logic [6:0] node_addr = 7'h2A;
   gsi_role_type cfg_role = GSI_ROLE_MB_MASTER;
   logic [7:0] mb_func = 8'h00;
   logic dbl_go = 1'h0;
   logic led_err, led_run, led_tx, led_rx, cfg_mode, engine_rst, mb_func_ok;
   logic [6:0] seg_hi, seg_lo;
   gsi_role_type role;
   logic [3:0] can_cmd_en;
   int failures = 0;
   int samples_checked = 0;
   always #12.5 clk = ~clk; // 40 MHz.
   gsi_field #(.MS(MS)) i_field (.clk(clk), .dbl_go(dbl_go), .btn_n(btn_n));
   gsi_top #(.MS_CYC(MS)) i_dut (.clk(clk), .rst_n(rst_n), .btn_n(btn_n),
      .can_port_err(can_port_err), .can_err_warn(can_err_warn),
      .nmt_state(nmt_state), .can_tx_fail(can_tx_fail),
      .can_tx_ok(can_tx_ok), .ser_tx_act(ser_tx_act), .ser_rx_act(ser_rx_act),
      .ser_link_ok(ser_link_ok), .ser_err(ser_err), .node_addr(node_addr),
      .cfg_role(cfg_role), .mb_func(mb_func), .led_err(led_err),
      .led_run(led_run), .led_tx(led_tx), .led_rx(led_rx), .seg_hi(seg_hi),
      .seg_lo(seg_lo), .cfg_mode(cfg_mode), .engine_rst(engine_rst),
      .role(role), .can_cmd_en(can_cmd_en), .mb_func_ok(mb_func_ok));
   // Both digits as one readable word.
   function automatic logic [15:0] segs();
      return {1'h0, seg_hi, 1'h0, seg_lo};
   endfunction
   // Compare one result and count it.
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Let n edges pass, then settle past the last one.
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Wait a bounded time for engine_rst (sel high) or cfg_mode to reach v.
   task automatic wait_flag(logic sel, logic v, int ms);
      int n;
      n = 0;
      while ((sel ? engine_rst : cfg_mode) !== v && n < ms * MS) begin
         cyc(1);
         n++;
      end
      if (n >= ms * MS) begin
         failures++;
         $display("MISMATCH at %0t: wait timed out", $time);
      end
   endtask
   // Count the cycles each lamp is lit over a window of ms.
   task automatic duty(int ms, output int hi[4]);
      hi = '{0, 0, 0, 0};
      repeat (ms * MS) begin
         cyc(1);
         hi[0] += int'(led_err === 1'h1);
         hi[1] += int'(led_run === 1'h1);
         hi[2] += int'(led_tx === 1'h1);
         hi[3] += int'(led_rx === 1'h1);
      end
   endtask
   // One operator double press.
   task automatic press();
      @(posedge clk);
      dbl_go <= 1'h1;
      @(posedge clk);
      dbl_go <= 1'h0;
      // The operator model is busy for 320 ms and misses requests then.
      cyc(330 * MS);
   endtask
   // Power-up restart: lamp test, blank, then the address.
   task automatic t_restart();
      cyc(10);
      chk(segs(), 16'h7F7F);
      cyc(320 * MS);
      chk(segs(), 16'h0000);
      wait_flag(1'h1, 1'h0, 300);
      cyc(3);
      chk(16'(role), 16'(GSI_ROLE_MB_MASTER));
      chk(16'(can_cmd_en), 16'h0003);
      chk(segs(), 16'h665B);
   endtask
   // Lamp patterns for a table of bus and serial conditions.
   task automatic t_lamps();
      gsi_row_type rows[5];
      int hi[4];
      rows = '{'{1'h0, 1'h0, GSI_NMT_OPER, 4'hE, 400, '{0, 400, 200, 200}},
         '{1'h1, 1'h0, GSI_NMT_PREOP, 4'hA, 400, '{400, 200, 200, -1}},
         '{1'h0, 1'h1, GSI_NMT_STOP, 4'h6, 1200, '{600, 200, -1, 600}},
         '{1'h1, 1'h1, GSI_NMT_OPER, 4'hC, 400, '{400, 400, 0, 0}},
         '{1'h0, 1'h0, GSI_NMT_INIT, 4'hF, 400, '{0, 0, 0, 0}}};
      foreach (rows[r]) begin
         @(posedge clk);
         can_port_err <= rows[r].pe;
         can_err_warn <= rows[r].wn;
         nmt_state <= rows[r].st;
         {ser_tx_act, ser_rx_act, ser_link_ok, ser_err} <= rows[r].sr;
         cyc(3);
         duty(rows[r].win, hi);
         for (int i = 0; i < 4; i++) begin
            if (rows[r].e[i] >= 0) begin
               chk(16'((hi[i] + MS / 2) / MS), 16'(rows[r].e[i]));
            end
         end
      end
   endtask
   // Upper address limit, then a failed frame until a good one clears it.
   task automatic t_disp();
      @(posedge clk);
      node_addr <= 7'h63;
      cyc(3);
      chk(segs(), 16'h6F6F);
      @(posedge clk);
      node_addr <= 7'h64;
      can_tx_fail <= 1'h1;
      @(posedge clk);
      can_tx_fail <= 1'h0;
      cyc(5);
      chk(segs(), 16'h795C);
      @(posedge clk);
      can_tx_ok <= 1'h1;
      @(posedge clk);
      can_tx_ok <= 1'h0;
      cyc(3);
      chk(segs(), 16'h4040);
   endtask
   // Every function code from 00 to 11 hex in the serial master role.
   task automatic t_func();
      for (int f = 0; f < 18; f++) begin
         @(posedge clk);
         mb_func <= 8'(f);
         cyc(3);
         chk(16'(mb_func_ok), 16'((f > 0 && f < 7) || f == 15 || f == 16));
      end
   endtask
   // Enter configuration, change role, leave through a restart.
   task automatic t_cfg();
      press();
      wait_flag(1'h0, 1'h1, 400);
      cyc(3);
      chk(segs(), 16'h3971);
      @(posedge clk);
      cfg_role <= GSI_ROLE_CAN_MASTER;
      press();
      wait_flag(1'h1, 1'h1, 400);
      cyc(10);
      chk(segs(), 16'h7F7F);
      wait_flag(1'h1, 1'h0, 600);
      cyc(3);
      chk(16'(cfg_mode), 16'h0000);
      chk(16'(role), 16'(GSI_ROLE_CAN_MASTER));
      chk(16'(can_cmd_en), 16'h000F);
   endtask
   // Print the counts and the verdict, then stop.
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Main sequence after a two-cycle reset.
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      t_restart();
      t_lamps();
      t_disp();
      t_func();
      t_cfg();
      report_and_stop();
   end
   // Watchdog: tests take about 4.4 s scaled, near 1.1 ms of sim time.
   initial begin
      #2ms;
      failures++;
      report_and_stop();
   end
endmodule
